// ===== uti_pkg.sv
package uti_pkg;

	// operand width selection in the extension word
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;

	// extension word field positions
	localparam int EXT_SIGNED_BIT = 11;
	localparam int EXT_ROUND_BIT  = 10;
	localparam int EXT_TABLE_BIT  = 8;
	localparam int EXT_SIZE_LSB   = 6;
	localparam int EXT_DYN_LSB    = 0;

	// opcode word effective address field positions
	localparam int EA_MODE_LSB = 3;
	localparam int EA_REG_LSB  = 0;

	// addressing modes: data register form, plus the control modes accepted in table mode
	localparam logic [2:0] EA_MODE_DREG   = 3'h0;
	localparam logic [2:0] EA_MODE_IND    = 3'h2;
	localparam logic [2:0] EA_MODE_DISP   = 3'h5;
	localparam logic [2:0] EA_MODE_INDEX  = 3'h6;
	localparam logic [2:0] EA_MODE_EXT    = 3'h7;
	localparam logic [2:0] EA_REG_ABS_W   = 3'h0;
	localparam logic [2:0] EA_REG_PC_IDX  = 3'h3;

	// independent variable layout in the destination register
	localparam int FRAC_W    = 8;
	localparam int INDEX_LSB = 8;
	localparam int INDEX_W   = 8;

	// long unrounded results keep this many integer bits
	localparam int LONG_INT_W = 24;

	// one half of the adjusted difference fraction
	localparam logic [41:0] ROUND_HALF = 42'h00000000080;

	// reset values
	localparam logic [31:0] RESULT_RST = 32'h00000000;

endpackage : uti_pkg

// ===== uti_core.sv
`timescale 1ns/10ps

module uti_core
	import uti_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 32
) (
	// clock, reset, enable
	input  wire logic              CLK_SYS_I,
	input  wire logic              RST_I,
	input  wire logic              CE_I,
	// instruction request from the decoder
	input  wire logic              START_I,
	input  wire logic [15:0]       OPWORD_I,
	input  wire logic [15:0]       EXTWORD_I,
	input  wire logic [DATA_W-1:0] DEST_DATA_I,
	input  wire logic [DATA_W-1:0] SRC_M_DATA_I,
	input  wire logic [DATA_W-1:0] SRC_N_DATA_I,
	input  wire logic [ADDR_W-1:0] EA_ADDR_I,
	input  wire logic              X_FLAG_I,
	// table entry fetch
	output logic                   MEM_REQ_O,
	output logic [ADDR_W-1:0]      MEM_ADDR_O,
	output logic [1:0]             MEM_SIZE_O,
	input  wire logic              MEM_ACK_I,
	input  wire logic [DATA_W-1:0] MEM_DATA_I,
	// result and condition flags
	output logic                   BUSY_O,
	output logic                   DONE_O,
	output logic                   ILLEGAL_O,
	output logic [DATA_W-1:0]      RESULT_O,
	output logic                   FLAG_X_O,
	output logic                   FLAG_N_O,
	output logic                   FLAG_Z_O,
	output logic                   FLAG_V_O,
	output logic                   FLAG_C_O
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] size_mask(input logic [1:0] sz);
		unique case (sz)
			SIZE_BYTE: size_mask = 32'h000000FF;
			SIZE_WORD: size_mask = 32'h0000FFFF;
			default:   size_mask = 32'hFFFFFFFF;
		endcase
	endfunction

	function automatic logic [2:0] size_bytes(input logic [1:0] sz);
		unique case (sz)
			SIZE_BYTE: size_bytes = 3'h1;
			SIZE_WORD: size_bytes = 3'h2;
			default:   size_bytes = 3'h4;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_FETCH0 = 4'h2,
		ST_FETCH1 = 4'h4,
		ST_CALC   = 4'h8
	} uti_state_t;

	uti_state_t        state_ff;
	logic              round_ff;
	logic [1:0]        size_ff;
	logic [31:0]       dest_ff;
	logic [31:0]       entry0_ff;
	logic [31:0]       entry1_ff;

	////////////////////////////////////////////////////////////////////////////
	// request decode

	wire logic [2:0] ea_mode   = OPWORD_I[EA_MODE_LSB +: 3];
	wire logic [2:0] ea_reg    = OPWORD_I[EA_REG_LSB +: 3];
	wire logic [1:0] req_size  = EXTWORD_I[EXT_SIZE_LSB +: 2];
	wire logic       req_round = EXTWORD_I[EXT_ROUND_BIT];
	wire logic       req_table = EXTWORD_I[EXT_TABLE_BIT];

	wire logic size_ok     = (req_size != 2'h3);
	wire logic unsigned_ok = ~EXTWORD_I[EXT_SIGNED_BIT];

	wire logic ea_control = (ea_mode == EA_MODE_IND) ||
		(ea_mode == EA_MODE_DISP) || (ea_mode == EA_MODE_INDEX) ||
		((ea_mode == EA_MODE_EXT) && (ea_reg <= EA_REG_PC_IDX));

	// table bit and mode field must agree on which form is meant
	wire logic reg_mode = (ea_mode == EA_MODE_DREG);
	wire logic form_ok  = reg_mode ? ~req_table : (req_table & ea_control);

	wire logic req_legal = size_ok & unsigned_ok & form_ok;
	wire logic accept    = START_I & (state_ff == ST_IDLE);

	// first entry address: base plus index scaled by entry size
	wire logic [INDEX_W-1:0] index_byte = DEST_DATA_I[INDEX_LSB +: INDEX_W];
	wire logic [10:0] index_off = 11'(index_byte) * 11'(size_bytes(req_size));
	wire logic [ADDR_W-1:0] first_addr = EA_ADDR_I + ADDR_W'(index_off);
	wire logic [ADDR_W-1:0] next_addr  = MEM_ADDR_O + ADDR_W'(size_bytes(size_ff));

	// register mode: source m is entry n, source n is entry n+1
	wire logic [31:0] reg_entry0 = SRC_M_DATA_I[31:0] & size_mask(req_size);
	wire logic [31:0] reg_entry1 = SRC_N_DATA_I[31:0] & size_mask(req_size);
	wire logic [31:0] mem_entry  = MEM_DATA_I[31:0] & size_mask(size_ff);

	////////////////////////////////////////////////////////////////////////////
	// interpolation datapath

	wire logic [FRAC_W-1:0] frac = dest_ff[FRAC_W-1:0];

	// unsigned entries widen with a zero so the difference keeps its sign
	wire logic signed [32:0] diff = $signed({1'b0, entry1_ff}) - $signed({1'b0, entry0_ff});
	wire logic signed [41:0] adj  = diff * $signed({1'b0, frac});
	wire logic signed [41:0] base = $signed({2'h0, entry0_ff, 8'h00});
	// the sum lies between the two entries, so it is never negative
	wire logic signed [41:0] unrounded = base + adj;
	wire logic [41:0] rounded_sum = unrounded + ROUND_HALF;
	wire logic [31:0] rounded     = rounded_sum[39:8];
	wire logic [33:0] int_part    = unrounded[41:8];
	wire logic [7:0]  frac_part   = unrounded[7:0];

	wire logic [31:0] keep_mask = size_mask(size_ff);
	wire logic [31:0] rnd_value = (dest_ff & ~keep_mask) | (rounded & keep_mask);

	logic [31:0] unr_value;
	always_comb begin
		unique case (size_ff)
			SIZE_BYTE: unr_value = {16'h0000, int_part[7:0], frac_part};
			SIZE_WORD: unr_value = {8'h00, int_part[15:0], frac_part};
			default:   unr_value = {int_part[LONG_INT_W-1:0], frac_part};
		endcase
	end

	wire logic [31:0] final_value = round_ff ? unr_value : rnd_value;

	// rounded flags look at the written field; unrounded ones at the full register
	wire logic [31:0] flag_field = round_ff ? unr_value : (rounded & keep_mask);
	wire logic msb_byte = flag_field[7];
	wire logic msb_word = flag_field[15];
	wire logic msb_long = flag_field[31];
	wire logic res_neg  = round_ff ? msb_long :
		((size_ff == SIZE_BYTE) ? msb_byte : (size_ff == SIZE_WORD) ? msb_word : msb_long);
	wire logic res_zero = (flag_field == 32'h00000000);
	wire logic res_ovf  = round_ff & (size_ff == SIZE_LONG) &
		(|int_part[33:LONG_INT_W]);

	////////////////////////////////////////////////////////////////////////////
	// sequencing

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state_ff <= ST_IDLE;
		end else if (CE_I) begin
			unique case (state_ff)
				ST_IDLE: begin
					if (accept && req_legal) begin
						state_ff <= req_table ? ST_FETCH0 : ST_CALC;
					end
				end
				ST_FETCH0: begin
					if (MEM_ACK_I) begin
						state_ff <= ST_FETCH1;
					end
				end
				ST_FETCH1: begin
					if (MEM_ACK_I) begin
						state_ff <= ST_CALC;
					end
				end
				ST_CALC: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// operand capture
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			round_ff  <= 1'b0;
			size_ff   <= SIZE_BYTE;
			dest_ff   <= RESULT_RST;
			entry0_ff <= RESULT_RST;
			entry1_ff <= RESULT_RST;
		end else if (CE_I) begin
			if (accept && req_legal) begin
				round_ff  <= req_round;
				size_ff   <= req_size;
				dest_ff   <= DEST_DATA_I[31:0];
				entry0_ff <= reg_entry0;
				entry1_ff <= reg_entry1;
			end else if (MEM_ACK_I && state_ff == ST_FETCH0) begin
				entry0_ff <= mem_entry;
			end else if (MEM_ACK_I && state_ff == ST_FETCH1) begin
				entry1_ff <= mem_entry;
			end
		end
	end

	// entry fetch port: request stands until the second entry is acknowledged
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			MEM_REQ_O  <= 1'b0;
			MEM_ADDR_O <= '0;
			MEM_SIZE_O <= SIZE_BYTE;
		end else if (CE_I) begin
			if (accept && req_legal && req_table) begin
				MEM_REQ_O  <= 1'b1;
				MEM_ADDR_O <= first_addr;
				MEM_SIZE_O <= req_size;
			end else if (MEM_ACK_I && state_ff == ST_FETCH0) begin
				MEM_ADDR_O <= next_addr;
			end else if (MEM_ACK_I && state_ff == ST_FETCH1) begin
				MEM_REQ_O <= 1'b0;
			end
		end
	end

	// busy covers every cycle from acceptance to the done pulse
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			BUSY_O    <= 1'b0;
			DONE_O    <= 1'b0;
			ILLEGAL_O <= 1'b0;
		end else if (CE_I) begin
			DONE_O    <= (state_ff == ST_CALC);
			ILLEGAL_O <= accept & ~req_legal;
			if (accept && req_legal) begin
				BUSY_O <= 1'b1;
			end else if (state_ff == ST_CALC) begin
				BUSY_O <= 1'b0;
			end
		end
	end

	// result and N, Z, V, C hold until the next completed instruction; X is loaded at each legal acceptance
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			RESULT_O <= '0;
			FLAG_X_O <= 1'b0;
			FLAG_N_O <= 1'b0;
			FLAG_Z_O <= 1'b0;
			FLAG_V_O <= 1'b0;
			FLAG_C_O <= 1'b0;
		end else if (CE_I) begin
			if (accept && req_legal) begin
				FLAG_X_O <= X_FLAG_I;
			end
			if (state_ff == ST_CALC) begin
				RESULT_O <= DATA_W'(final_value);
				FLAG_N_O <= res_neg;
				FLAG_Z_O <= res_zero;
				FLAG_V_O <= res_ovf;
				FLAG_C_O <= 1'b0;
			end
		end
	end

endmodule // uti_core

// ===== uti_mem_model.sv
`timescale 1ns/10ps
module uti_mem_model (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_I,
	input  wire logic [1:0]  DLY_I,
	input  wire logic        MEM_REQ_I,
	input  wire logic [31:0] MEM_ADDR_I,
	output logic             MEM_ACK_O,
	output logic [31:0]      MEM_DATA_O
);
	logic [1:0] wait_ff;
	// content is a hash of the address so the bench can predict every entry
	wire [31:0] word = MEM_ADDR_I * 32'h9E3779B1 + 32'h0F1E2D3C;
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I || !MEM_REQ_I || MEM_ACK_O)
			wait_ff <= DLY_I;
		else
			wait_ff <= wait_ff - 2'h1;
	end
	assign MEM_ACK_O = MEM_REQ_I && wait_ff == 2'h0;
	// off the ack the bus shows junk, never the last good word
	assign MEM_DATA_O = MEM_ACK_O ? word : ~word;
endmodule // uti_mem_model

// ===== uti_core_monitor.sv
`timescale 1ns/10ps
module uti_core_monitor
	import uti_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 32
) (
	input wire logic              CLK_SYS_I,
	input wire logic              RST_I,
	input wire logic              CE_I,
	input wire logic              START_I,
	input wire logic [15:0]       OPWORD_I,
	input wire logic [15:0]       EXTWORD_I,
	input wire logic [DATA_W-1:0] DEST_DATA_I,
	input wire logic [ADDR_W-1:0] EA_ADDR_I,
	input wire logic              MEM_REQ_O,
	input wire logic [ADDR_W-1:0] MEM_ADDR_O,
	input wire logic [1:0]        MEM_SIZE_O,
	input wire logic              MEM_ACK_I,
	input wire logic              BUSY_O,
	input wire logic              DONE_O,
	input wire logic              ILLEGAL_O,
	input wire logic [DATA_W-1:0] RESULT_O,
	input wire logic              FLAG_Z_O,
	input wire logic              FLAG_V_O,
	input wire logic              FLAG_C_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	logic [15:0]       ext_ff;
	logic [DATA_W-1:0] dst_ff;
	logic              second_ff;
	wire [2:0] md   = OPWORD_I[5:3];
	wire       fit  = !EXTWORD_I[11] && EXTWORD_I[7:6] != 2'h3;
	wire       tbl  = EXTWORD_I[8] && (md == EA_MODE_IND || md == EA_MODE_DISP || md == EA_MODE_INDEX
		|| (md == EA_MODE_EXT && !OPWORD_I[2]));
	wire       take = START_I && CE_I && !BUSY_O;
	wire       ack  = MEM_REQ_O && MEM_ACK_I && CE_I;
	always_ff @(posedge CLK_SYS_I) begin
		if (take)
			ext_ff <= EXTWORD_I;
		if (take)
			dst_ff <= DEST_DATA_I;
		second_ff <= RST_I ? 1'b0 : second_ff ^ ack;
	end
	sequence first_ack_s;
		ack && !second_ff;
	endsequence
	sequence last_ack_s;
		ack && second_ff;
	endsequence
	entry_addr_a: assert property (take && fit && tbl |=> MEM_REQ_O && MEM_ADDR_O ==
		$past(EA_ADDR_I) + (ADDR_W'($past(DEST_DATA_I[15:8])) << $past(EXTWORD_I[7:6])))
		else $error("first entry address wrong");
	next_entry_a: assert property (first_ack_s |=> MEM_REQ_O &&
		MEM_ADDR_O == $past(MEM_ADDR_O) + (ADDR_W'(1) << MEM_SIZE_O)) else $error("second entry address wrong");
	fetch_end_a: assert property (last_ack_s |=> !MEM_REQ_O ##1 DONE_O) else $error("no result after fetch");
	reg_latency_a: assert property (take && fit && md == 3'h0 && !EXTWORD_I[8] |=>
		BUSY_O && !MEM_REQ_O ##1 DONE_O) else $error("register mode timing wrong");
	refuse_a: assert property (take && !(fit && (md == 3'h0 ? !EXTWORD_I[8] : tbl)) |=>
		ILLEGAL_O && !BUSY_O && !MEM_REQ_O) else $error("bad request not refused");
	flag_cv_a: assert property (DONE_O |-> !FLAG_C_O &&
		(FLAG_V_O -> ext_ff[10] && ext_ff[7:6] == SIZE_LONG)) else $error("carry or overflow wrong");
	zero_flag_a: assert property (DONE_O && ext_ff[10] |-> FLAG_Z_O == (RESULT_O == '0))
		else $error("zero flag wrong");
	keep_bits_a: assert property (DONE_O && !ext_ff[10] && ext_ff[7:6] == SIZE_BYTE |->
		RESULT_O[31:8] == dst_ff[31:8]) else $error("upper bits disturbed");
	zero_ext_a: assert property (DONE_O && ext_ff[10] && ext_ff[7:6] != SIZE_LONG |->
		RESULT_O[31:24] == 8'h00) else $error("not zero extended");
endmodule // uti_core_monitor

// ===== unsigned_table_interpolator_test.sv
`timescale 1ns/10ps
module unsigned_table_interpolator_test;
	import uti_pkg::*;
	logic        CLK_SYS_I, RST_I, CE_I, START_I, X_FLAG_I, MEM_ACK_I, MEM_REQ_O, BUSY_O, DONE_O, ILLEGAL_O;
	logic        FLAG_X_O, FLAG_N_O, FLAG_Z_O, FLAG_V_O, FLAG_C_O;
	logic [15:0] OPWORD_I, EXTWORD_I;
	logic [31:0] DEST_DATA_I, SRC_M_DATA_I, SRC_N_DATA_I, EA_ADDR_I, MEM_ADDR_O, MEM_DATA_I, RESULT_O, r;
	logic [1:0]  MEM_SIZE_O, dly;
	logic [2:0]  md;
	int          n_mismatch, check_count, seed, i, k;
	uti_core u_dut (.*);
	uti_mem_model u_mem (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .DLY_I(dly), .MEM_REQ_I(MEM_REQ_O),
		.MEM_ADDR_I(MEM_ADDR_O), .MEM_ACK_O(MEM_ACK_I), .MEM_DATA_O(MEM_DATA_I));
	initial begin
		CLK_SYS_I = 1'b0;
		forever #5 CLK_SYS_I = ~CLK_SYS_I;
	end
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("compares %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask
	// returns {overflow, negative, zero, new destination}
	function automatic logic [34:0] expect_res(input logic [31:0] e0, e1, d, m, input logic un);
		logic [47:0] v;
		logic [31:0] q;
		v = {8'h0, e0, 8'h0} + 48'(e1) * d[7:0] - 48'(e0) * d[7:0];
		if (!un) begin
			q = 32'((v + 48'h80) >> 8) & m;
			return {1'b0, |(q & ~(m >> 1)), q == 32'h0, (d & ~m) | q};
		end
		q = v[31:0] & {m[23:0], 8'hFF};
		return {m[31] && |v[47:32], q[31], q == 32'h0, q};
	endfunction
	task automatic run(input logic [15:0] op, ext, input logic [31:0] d, sm, sn, ea, input logic hold);
		logic        ok;
		logic [1:0]  sz;
		logic [31:0] m, a;
		logic [34:0] x;
		sz = ext[7:6];
		ok = !ext[11] && sz != 2'h3 && (op[5:3] == 3'h0 ? !ext[8] : ext[8]
			&& (op[5:3] inside {3'h2, 3'h5, 3'h6} || (op[5:3] == 3'h7 && !op[2])));
		m = sz == SIZE_BYTE ? 32'hFF : sz == SIZE_WORD ? 32'hFFFF : 32'hFFFFFFFF;
		a = ea + (32'(d[15:8]) << sz);
		x = expect_res(op[5:3] == 3'h0 ? sm & m : (a * 32'h9E3779B1 + 32'h0F1E2D3C) & m,
			op[5:3] == 3'h0 ? sn & m : ((a + (32'h1 << sz)) * 32'h9E3779B1 + 32'h0F1E2D3C) & m, d, m, ext[10]);
		@(posedge CLK_SYS_I);
		{START_I, OPWORD_I, EXTWORD_I, DEST_DATA_I} <= {1'b1, op, ext, d};
		{SRC_M_DATA_I, SRC_N_DATA_I, EA_ADDR_I, X_FLAG_I} <= {sm, sn, ea, op[15]};
		@(posedge CLK_SYS_I);
		START_I <= hold && ok; // a repeat while busy must be ignored
		// the refusal pulse stands only in this cycle, so look after it settles
		#1;
		for (k = 0; k < 40 && DONE_O !== 1'b1 && ILLEGAL_O !== 1'b1; k++) begin
			@(posedge CLK_SYS_I);
			START_I <= 1'b0;
			#1;
		end
		if (k == 40) begin
			check(1'b0, "no answer");
			stop_test();
		end else begin
			check(ILLEGAL_O === !ok && DONE_O === ok, "refusal");
			if (ok)
				check(RESULT_O === x[31:0], "result");
			if (ok)
				check({FLAG_X_O, FLAG_N_O, FLAG_Z_O, FLAG_V_O, FLAG_C_O} === {op[15], x[33:32], x[34], 1'b0}, "flags");
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 20;
		dly = 2'h0;
		{RST_I, CE_I, START_I, X_FLAG_I, OPWORD_I, EXTWORD_I, DEST_DATA_I, SRC_M_DATA_I, SRC_N_DATA_I, EA_ADDR_I} = '0;
		RST_I = 1'b1;
		CE_I = 1'b1;
		repeat (16) @(posedge CLK_SYS_I);
		RST_I <= 1'b0;
		run(16'h0000, 16'h0000, 32'hAABBCC80, 32'h0, 32'h1, 32'h0, 1'b0);
		run(16'h8000, 16'h0480, 32'h12345601, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 1'b0);
		run(16'h0010, 16'h0540, 32'h0000FFFF, 32'h0, 32'h0, 32'h100, 1'b1);
		for (i = 0; i < 16; i++)
			run({10'h0, 3'(i >> 1), i[0] ? 3'h4 : 3'h1}, 16'h0100, 32'h00000340, 32'h0, 32'h0, 32'h2000, 1'b0);
		for (i = 0; i < 300; i++) begin
			r = $random(seed);
			dly <= r[12:11];
			md = r[14] ? 3'h0 : r[17:16] == 2'h0 ? 3'h2 : r[17:16] == 2'h1 ? 3'h5 : {2'h3, r[16]};
			// unused register field stays zero in table mode
			run({r[31:22], md, md == 3'h0 ? r[10:8] : {1'b0, r[9:8]}}, {4'h0, &r[2:0], r[3], 1'b0, md != 3'h0,
				r[5:4], 3'h0, md == 3'h0 ? r[20:18] : 3'h0}, $random(seed), r[15] ? 32'h0 : $random(seed),
				r[15] ? 32'h0 : $random(seed), $random(seed), r[13]);
		end
		stop_test();
	end
endmodule // unsigned_table_interpolator_test
bind uti_core uti_core_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mon (.*);
